// >>> rtl/qssr_map.vh
// Constants for the quad static shift register block
`ifndef QSSR_MAP_VH
`define QSSR_MAP_VH

// Register length, default and legal range
`define QSSR_LEN_DEFAULT 80
`define QSSR_LEN_STD_B   81
`define QSSR_LEN_STD_C   133
`define QSSR_LEN_MIN     1
`define QSSR_LEN_MAX     134

// System clock rate
`define QSSR_CLK_MHZ     40

// Least pulse widths on the pins, in nanoseconds
`define QSSR_PWH_NS      300
`define QSSR_PWL_NS      600
`define QSSR_CLR_PW_NS   20000

// Least widths as system clock cycles, rounded up
`define QSSR_PWH_CYC ((`QSSR_PWH_NS * `QSSR_CLK_MHZ + 999) / 1000)
`define QSSR_PWL_CYC ((`QSSR_PWL_NS * `QSSR_CLK_MHZ + 999) / 1000)
`define QSSR_CLR_CYC ((`QSSR_CLR_PW_NS * `QSSR_CLK_MHZ + 999) / 1000)

// Width of the pulse width counters, saturating
`define QSSR_CNT_W       10

// Number of pin inputs passed through the synchroniser
`define QSSR_SYNC_W      9

`endif

// >>> rtl/qssr_sync.v
// Two flip-flop synchroniser for a group of pin inputs
`default_nettype none
module qssr_sync #(
  parameter WIDTH = 1
) (
  // Clock and reset
  input  wire             clock,
  input  wire             rstn,
  // Asynchronous pins in, synchronised levels out
  input  wire [WIDTH-1:0] pin_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_reg;   // First stage, read only by second stage
  reg [WIDTH-1:0] sync_reg;   // Second stage, safe for logic

  // Two stages in a row; reset clears both to low
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      meta_reg <= {WIDTH{1'b0}};
      sync_reg <= {WIDTH{1'b0}};
    end
    else
    begin
      meta_reg <= pin_in;
      sync_reg <= meta_reg;
    end
  end

  assign sync_out = sync_reg;

endmodule // qssr_sync
`default_nettype wire

// >>> rtl/qssr_lane.v
// One serial shift register lane of programmable length
`default_nettype none
module qssr_lane #(
  parameter LEN = 80
) (
  // Clock and resets
  input  wire clock,
  input  wire rstn,
  input  wire clr_async,
  input  wire clr_sync,
  // Shift control and data
  input  wire shift_en,
  input  wire din,
  output wire dout
);

  reg  [LEN-1:0] stage_reg;   // All stages, bit 0 is the first
  wire [LEN-1:0] stage_next;  // Contents after one shift

  // Single stage lane needs no part-select of the old contents
  generate
    if (LEN == 1)
    begin : g_one
      assign stage_next = din;
    end
    else
    begin : g_many
      assign stage_next = {stage_reg[LEN-2:0], din};
    end
  endgenerate

  // Pin clear acts at once; static hold while no shift edge
  always @(posedge clock or posedge clr_async)
  begin
    if (clr_async)
      stage_reg <= {LEN{1'b0}};
    else if (!rstn || clr_sync)
      stage_reg <= {LEN{1'b0}};
    else if (shift_en)
      stage_reg <= stage_next;
  end

  // Output is the last stage, a flop bit
  assign dout = stage_reg[LEN-1];

endmodule // qssr_lane
`default_nettype wire

// >>> rtl/qssr_top.v
// Quad static shift register: pins, shift control and four lanes
`include "qssr_map.vh"
`default_nettype none
module qssr_top #(
  parameter LEN = `QSSR_LEN_DEFAULT  // Stages per lane, 1 to 134
) (
  // System clock and reset
  input  wire clock,
  input  wire rstn,
  // Shift clock pin from the host
  input  wire shift_clk,
  // Serial data inputs
  input  wire in_a,
  input  wire in_b,
  input  wire in_c,
  input  wire in_d,
  // Loop controls and alternate input of lane D
  input  wire loop_ctl_abc,
  input  wire loop_ctl_d,
  input  wire loop_in_d,
  // Clear pin, active high
  input  wire clear_all,
  // Serial data outputs
  output wire out_a,
  output wire out_b,
  output wire out_c,
  output wire out_d,
  // Pin timing fault, sticky until clear or reset
  output reg  timing_fault
);

  // Control states, one-hot
  localparam [2:0] ST_ARM   = 3'h1;  // Waiting for shift clock low
  localparam [2:0] ST_RUN   = 3'h2;  // Shifting on rising edges
  localparam [2:0] ST_CLEAR = 3'h4;  // Clear pin held

  // Limits worked out at full integer width, then cut on purpose
  // to the counter width; every limit fits in the counter
  localparam integer PWH_INT = `QSSR_PWH_CYC;
  localparam integer PWL_INT = `QSSR_PWL_CYC;
  localparam integer CLR_INT = `QSSR_CLR_CYC;
  localparam [`QSSR_CNT_W-1:0] PWH_LIM = PWH_INT[`QSSR_CNT_W-1:0];
  localparam [`QSSR_CNT_W-1:0] PWL_LIM = PWL_INT[`QSSR_CNT_W-1:0];
  localparam [`QSSR_CNT_W-1:0] CLR_LIM = CLR_INT[`QSSR_CNT_W-1:0];
  localparam [`QSSR_CNT_W-1:0] CNT_MAX = {`QSSR_CNT_W{1'b1}};

  // Synchronised pin levels
  wire [`QSSR_SYNC_W-1:0] pin_bus;   // Raw pins, gathered
  wire [`QSSR_SYNC_W-1:0] pin_sync;  // After two flops
  wire       clk_s;                  // Shift clock level
  wire       a_s;                    // Data A
  wire       b_s;                    // Data B
  wire       c_s;                    // Data C
  wire       d_s;                    // Data D
  wire       loop_abc_s;             // Shared loop control
  wire       loop_d_s;               // Loop control of D
  wire       loop_in_s;              // Alternate input of D
  wire       clear_s;                // Clear level

  // Edge and state registers
  reg        clk_prev_reg;           // Shift clock one cycle ago
  reg        clear_prev_reg;         // Clear one cycle ago
  reg  [2:0] state_reg;              // Control state
  reg  [2:0] state_next;             // Next control state
  reg  [`QSSR_CNT_W-1:0] high_cnt_reg;  // Cycles shift clock high
  reg  [`QSSR_CNT_W-1:0] low_cnt_reg;   // Cycles shift clock low
  reg  [`QSSR_CNT_W-1:0] clr_cnt_reg;   // Cycles clear held
  reg        fault_next;             // Next value of the fault flag

  // Edge detection and derived controls
  wire       clk_rise;               // Shift clock rose
  wire       clk_fall;               // Shift clock fell
  wire       clear_fall;             // Clear released
  wire       shift_en;               // One-cycle shift pulse
  wire       lane_clr;               // Synchronous lane clear
  wire       short_high;             // High phase too short
  wire       short_low;              // Low phase too short
  wire       short_clear;            // Clear pulse too short

  // Lane inputs after the loop selectors
  wire       feed_a;                 // First stage input, lane A
  wire       feed_b;                 // First stage input, lane B
  wire       feed_c;                 // First stage input, lane C
  wire       feed_d;                 // First stage input, lane D

  // Gather every pin so they share one synchroniser
  assign pin_bus = {clear_all, loop_in_d, loop_ctl_d, loop_ctl_abc,
                    in_d, in_c, in_b, in_a, shift_clk};

  // Every pin crosses two flops, but clear_all also drives the lane clears directly
  qssr_sync #(
    .WIDTH (`QSSR_SYNC_W)
  ) u_sync (
    .clock    (clock),
    .rstn     (rstn),
    .pin_in   (pin_bus),
    .sync_out (pin_sync)
  );

  // Name the synchronised levels
  assign clk_s      = pin_sync[0];
  assign a_s        = pin_sync[1];
  assign b_s        = pin_sync[2];
  assign c_s        = pin_sync[3];
  assign d_s        = pin_sync[4];
  assign loop_abc_s = pin_sync[5];
  assign loop_d_s   = pin_sync[6];
  assign loop_in_s  = pin_sync[7];
  assign clear_s    = pin_sync[8];

  // Previous levels for edge detection
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      clk_prev_reg   <= 1'b0;
      clear_prev_reg <= 1'b0;
    end
    else
    begin
      clk_prev_reg   <= clk_s;
      clear_prev_reg <= clear_s;
    end
  end

  // Edges of the synchronised levels
  assign clk_rise   = clk_s & ~clk_prev_reg;
  assign clk_fall   = ~clk_s & clk_prev_reg;
  assign clear_fall = ~clear_s & clear_prev_reg;

  // Data and clock share the same latency, so data sampled at
  // the detected edge is the data set up before the pin edge
  // Without edges nothing moves: contents hold however long
  // the shift clock stays still, in either level
  assign shift_en = clk_rise & state_reg[1];

  // Lanes stay clear while the synchronised clear is high, which
  // covers the gap after the pin clear drops
  assign lane_clr = clear_s | state_reg[2];

  // Next control state
  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      ST_ARM:
      begin
        // Host keeps the shift clock low between pulses, so a
        // high level after clear or reset is no shift edge
        if (clear_s)
          state_next = ST_CLEAR;
        else if (!clk_s)
          state_next = ST_RUN;
      end
      ST_RUN:
      begin
        if (clear_s)
          state_next = ST_CLEAR;
      end
      ST_CLEAR:
      begin
        if (!clear_s)
          state_next = ST_ARM;
      end
      default:
      begin
        state_next = ST_ARM;
      end
    endcase
  end

  // Control state register
  always @(posedge clock)
  begin
    if (!rstn)
      state_reg <= ST_ARM;
    else
      state_reg <= state_next;
  end

  // Shared loop control: A, B, C feed back their own outputs
  assign feed_a = loop_abc_s ? out_a : a_s;
  assign feed_b = loop_abc_s ? out_b : b_s;
  assign feed_c = loop_abc_s ? out_c : c_s;

  // Lane D picks the alternate input under its own control
  assign feed_d = loop_d_s ? loop_in_s : d_s;

  // Four identical lanes of one common length; feeding the
  // output back rotates the pattern one place per edge
  qssr_lane #(
    .LEN (LEN)
  ) u_lane_a (
    .clock     (clock),
    .rstn      (rstn),
    .clr_async (clear_all),
    .clr_sync  (lane_clr),
    .shift_en  (shift_en),
    .din       (feed_a),
    .dout      (out_a)
  );

  qssr_lane #(
    .LEN (LEN)
  ) u_lane_b (
    .clock     (clock),
    .rstn      (rstn),
    .clr_async (clear_all),
    .clr_sync  (lane_clr),
    .shift_en  (shift_en),
    .din       (feed_b),
    .dout      (out_b)
  );

  qssr_lane #(
    .LEN (LEN)
  ) u_lane_c (
    .clock     (clock),
    .rstn      (rstn),
    .clr_async (clear_all),
    .clr_sync  (lane_clr),
    .shift_en  (shift_en),
    .din       (feed_c),
    .dout      (out_c)
  );

  // Lane D has separate selection but the same shift pulse
  qssr_lane #(
    .LEN (LEN)
  ) u_lane_d (
    .clock     (clock),
    .rstn      (rstn),
    .clr_async (clear_all),
    .clr_sync  (lane_clr),
    .shift_en  (shift_en),
    .din       (feed_d),
    .dout      (out_d)
  );

  // Pulse width counters, saturating so a stopped clock is legal
  // Counts are in system clock cycles of the synchronised pins
  always @(posedge clock)
  begin
    if (!rstn)
    begin
      high_cnt_reg <= {`QSSR_CNT_W{1'b0}};
      // The pin rests low through reset, so the low phase that
      // follows counts as long: no false fault on the first rise
      low_cnt_reg  <= CNT_MAX;
      clr_cnt_reg  <= {`QSSR_CNT_W{1'b0}};
    end
    else
    begin
      // High phase counter restarts at each rising edge
      if (clk_rise)
        high_cnt_reg <= {{(`QSSR_CNT_W-1){1'b0}}, 1'b1};
      else if (clk_s && high_cnt_reg != CNT_MAX)
        high_cnt_reg <= high_cnt_reg + 1'b1;
      // Low phase counter restarts at each falling edge
      if (clk_fall)
        low_cnt_reg <= {{(`QSSR_CNT_W-1){1'b0}}, 1'b1};
      else if (!clk_s && low_cnt_reg != CNT_MAX)
        low_cnt_reg <= low_cnt_reg + 1'b1;
      // Clear counter runs while clear is held
      if (!clear_s)
        clr_cnt_reg <= {`QSSR_CNT_W{1'b0}};
      else if (clr_cnt_reg != CNT_MAX)
        clr_cnt_reg <= clr_cnt_reg + 1'b1;
    end
  end

  // Phases found too short when they end; the low phase is only
  // judged once running, since reset and clear cut it short
  assign short_high  = clk_fall & (high_cnt_reg < PWH_LIM);
  assign short_low   = clk_rise & state_reg[1] &
                       (low_cnt_reg < PWL_LIM);
  assign short_clear = clear_fall & (clr_cnt_reg < CLR_LIM);

  // Fault flag: set wins over the clear at release
  // so a short clear is not lost in its own clearing
  always @*
  begin
    fault_next = timing_fault;
    if (short_high || short_low || short_clear)
      fault_next = 1'b1;
    else if (clear_s)
      fault_next = 1'b0;
  end

  // Fault flag register; a short clear is reported after release
  // The flag is a diagnostic only and never stops shifting
  always @(posedge clock)
  begin
    if (!rstn)
      timing_fault <= 1'b0;
    else
      timing_fault <= fault_next;
  end

endmodule // qssr_top
`default_nettype wire

// >>> sim/qssr_host_model.sv
// Host-side model that drives the shift clock pin
`default_nettype none
module qssr_host_model (
  // Clock and pulse request
  input  wire logic       clock,
  input  wire logic       req,
  input  wire logic [5:0] hi_cyc,
  // Shift clock pin and status
  output logic            shift_clk,
  output logic            busy
);
  timeunit 1ns;
  timeprecision 100ps;

  // One shift pulse per request; the pin rests low between pulses
  initial
  begin
    shift_clk = 1'b0;
    busy = 1'b0;
    forever
    begin
      @(posedge clock);
      if (req)
      begin
        busy <= 1'b1;
        // Four cycles of setup keep data ahead of the rise
        repeat (4) @(posedge clock);
        shift_clk <= 1'b1;
        repeat (hi_cyc) @(posedge clock);
        shift_clk <= 1'b0;
        // Low phase well over the least width
        repeat (26) @(posedge clock);
        busy <= 1'b0;
      end
    end
  end
endmodule  // qssr_host_model
`default_nettype wire

// >>> sim/qssr_monitor.sv
// Checker of the quad shift register pins
`default_nettype none
module qssr_monitor (
  // Clock, reset and host pins
  input wire logic clock,
  input wire logic rstn,
  input wire logic shift_clk,
  input wire logic loop_ctl_abc,
  input wire logic clear_all,
  // Outputs of the block
  input wire logic out_a,
  input wire logic out_b,
  input wire logic out_c,
  input wire logic out_d,
  input wire logic timing_fault
);
  timeunit 1ns;
  timeprecision 100ps;

  wire  [3:0] outs = {out_d, out_c, out_b, out_a};  // All lanes
  logic       prev_reg;  // Shift clock last cycle
  logic [5:0] age_reg;   // Cycles since a shift rise
  logic [5:0] hi_reg;    // Cycles the shift clock has been high
  logic [9:0] cl_reg;    // Cycles clear has been high
  logic [2:0] clq_reg;   // Recent clear history, covers the sync lag

  // Saturating history counters
  always @(posedge clock)
  begin
    prev_reg <= shift_clk;
    clq_reg <= {clq_reg[1:0], clear_all};
    if (!rstn)
      age_reg <= 6'h3F;
    else if (shift_clk && !prev_reg)
      age_reg <= 6'h00;
    else if (age_reg != 6'h3F)
      age_reg <= age_reg + 6'h01;
    hi_reg <= !shift_clk ? 6'h00 : hi_reg + {5'h00, hi_reg != 6'h3F};
    cl_reg <= !clear_all ? 10'h000 : cl_reg + {9'h000, cl_reg != 10'h3FF};
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_clear_outs: assert property (clear_all |-> outs == 4'h0)
    else $error("outputs not low while clear is high");
  a_out_cause: assert property ((outs != $past(outs)) && !clear_all
    && !$past(clear_all) |-> age_reg <= 6'h06)
    else $error("output moved without a shift rise");
  a_hold_high: assert property (disable iff (!rstn || clear_all)
    shift_clk [*8] |-> $stable(outs))
    else $error("output moved while shift clock held high");
  a_hold_low: assert property (disable iff (!rstn || clear_all)
    !shift_clk [*8] |-> $stable(outs))
    else $error("output moved while shift clock held low");
  a_fault_short: assert property ($fell(shift_clk)
    && hi_reg < 6'h0A |-> ##[1:6] timing_fault)
    else $error("short high phase not flagged");
  a_fault_sticky: assert property (disable iff
    (!rstn || clear_all || |clq_reg) timing_fault |=> timing_fault)
    else $error("fault flag dropped by itself");
  a_fault_clear: assert property (clear_all [*4] |-> !timing_fault)
    else $error("clear left the fault flag set");
  a_clear_width: assert property ($fell(clear_all)
    && cl_reg < 10'h2BC |-> ##[1:6] timing_fault)
    else $error("short clear not flagged");

  c_shift_loop: cover property ($rose(shift_clk) && loop_ctl_abc);
  c_fault: cover property ($rose(timing_fault));
  c_clear: cover property ($fell(clear_all));
endmodule  // qssr_monitor

bind qssr_top qssr_monitor u_mon (.clock(clock), .rstn(rstn),
  .shift_clk(shift_clk), .loop_ctl_abc(loop_ctl_abc),
  .clear_all(clear_all), .out_a(out_a), .out_b(out_b), .out_c(out_c),
  .out_d(out_d), .timing_fault(timing_fault));
`default_nettype wire

// >>> sim/quad_static_shift_register_tb.sv
// Self-checking bench for the quad shift register
`default_nettype none
module quad_static_shift_register_tb;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int LEN = 4;  // Short lanes keep the table small
  logic       clock, rstn, req, loop_ctl_abc, loop_ctl_d, loop_in_d;
  logic       clear_all;
  logic [3:0] pins;      // Data pins as {d, c, b, a}
  logic [5:0] hi_cyc;    // High phase asked of the host model
  wire        shift_clk, busy, timing_fault;
  wire        out_a, out_b, out_c, out_d;
  wire  [3:0] outs_one;  // Outputs of the one-stage build, {d, c, b, a}
  int         num_errors, check_count, i;
  // Row: pins, {0, loop abc, loop d, alternate bit}, expected outputs
  logic [11:0] rows [12] = '{12'h510, 12'h610, 12'hB00, 12'h905,
    12'h276, 12'h96B, 12'hC69, 12'h67D, 12'hA06, 12'h903, 12'h419,
    12'h61A};

  qssr_top #(.LEN(LEN)) DUT (.clock(clock), .rstn(rstn),
    .shift_clk(shift_clk), .in_a(pins[0]), .in_b(pins[1]),
    .in_c(pins[2]), .in_d(pins[3]), .loop_ctl_abc(loop_ctl_abc),
    .loop_ctl_d(loop_ctl_d), .loop_in_d(loop_in_d),
    .clear_all(clear_all), .out_a(out_a), .out_b(out_b), .out_c(out_c),
    .out_d(out_d), .timing_fault(timing_fault));
  qssr_host_model u_host (.clock(clock), .req(req), .hi_cyc(hi_cyc),
    .shift_clk(shift_clk), .busy(busy));
  // Single-stage build on the same pins, the shortest legal length
  qssr_top #(.LEN(1)) DUT1 (.clock(clock), .rstn(rstn),
    .shift_clk(shift_clk), .in_a(pins[0]), .in_b(pins[1]),
    .in_c(pins[2]), .in_d(pins[3]), .loop_ctl_abc(loop_ctl_abc),
    .loop_ctl_d(loop_ctl_d), .loop_in_d(loop_in_d),
    .clear_all(clear_all), .out_a(outs_one[0]), .out_b(outs_one[1]),
    .out_c(outs_one[2]), .out_d(outs_one[3]), .timing_fault());

  // Verdict and end of run
  task automatic results();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // Compare a group of output bits
  task automatic compare(string what, logic [3:0] exp, logic [3:0] got);
    check_count++;
    if (got !== exp)
    begin
      $display("[ERR] %s expected %h seen %h", what, exp, got);
      num_errors++;
    end
  endtask

  // Set pins at a rising edge, then one shift pulse; bounded wait
  task automatic shift(logic [11:0] r, logic [5:0] hi);
    int n;
    @(posedge clock);
    pins <= r[11:8];
    {loop_ctl_abc, loop_ctl_d, loop_in_d} <= r[6:4];
    hi_cyc <= hi;
    req <= 1'b1;
    @(posedge clock);
    req <= 1'b0;
    @(negedge clock);
    n = 0;
    while (busy !== 1'b0 && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    if (n == 200)
    begin
      num_errors++;
      results();
    end
  endtask

  // Hold clear for a number of cycles
  task automatic clear_for(int cyc);
    @(posedge clock);
    clear_all <= 1'b1;
    @(negedge clock);
    compare("clear outs", 4'h0, {out_d, out_c, out_b, out_a});
    repeat (cyc) @(posedge clock);
    clear_all <= 1'b0;
    repeat (8) @(negedge clock);
  endtask

  // 40 MHz clock
  initial
  begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // Hang guard
  initial
  begin
    repeat (50000) @(posedge clock);
    num_errors++;
    results();
  end

  // Main sequence
  initial
  begin
    {rstn, req, loop_ctl_abc, loop_ctl_d, loop_in_d, clear_all} = 6'h00;
    pins = 4'h0;
    hi_cyc = 6'h0E;
    num_errors = 0;
    check_count = 0;
    repeat (5) @(posedge clock);
    rstn <= 1'b1;
    repeat (6) @(negedge clock);
    compare("reset outs", 4'h0, {out_d, out_c, out_b, out_a});
    // Load, recirculate A to C while D takes the alternate bit, load again
    for (i = 0; i < 12; i++)
    begin
      shift(rows[i], 6'h0E);
      compare("row outs", rows[i][3:0], {out_d, out_c, out_b, out_a});
    end
    compare("no fault", 4'h0, {3'h0, timing_fault});
    // Stopped shift clock keeps the contents
    repeat (300) @(negedge clock);
    compare("held outs", 4'hA, {out_d, out_c, out_b, out_a});
    // Long clear empties every stage, then shifting resumes
    clear_for(810);
    compare("fault after clear", 4'h0, {3'h0, timing_fault});
    for (i = 1; i <= LEN; i++)
    begin
      shift({(i == 1) ? 4'hF : 4'h0, 8'h00}, 6'h0E);
      compare("after clear", (i == LEN) ? 4'hF : 4'h0,
        {out_d, out_c, out_b, out_a});
      compare("one stage", (i == 1) ? 4'hF : 4'h0, outs_one);
    end
    // Short high phase is flagged
    shift(12'h000, 6'h05);
    compare("short pulse fault", 4'h1, {3'h0, timing_fault});
    // Short clear clears the flag, then flags its own width
    clear_for(100);
    compare("short clear fault", 4'h1, {3'h0, timing_fault});
    results();
  end
endmodule  // quad_static_shift_register_tb
`default_nettype wire
